// File: dso_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH

`define DSO_OFS_OUT_CFG4   8'h00
`define DSO_OFS_BRI_CFG0   8'h04
`define DSO_OFS_BRI_CFG1   8'h08
`define DSO_OFS_DD_CFG2    8'h0c
`define DSO_OFS_COMMAND_REG_ZERO       8'h10
`define DSO_OFS_EN_CMD     8'h14
`define DSO_OFS_EN_CFG2    8'h18
`define DSO_OFS_OP_STAT1   8'h1c

`define DSO_BIT_DMODE_A    0
`define DSO_BIT_OL_A       1
`define DSO_BIT_OC_A       2
`define DSO_BIT_FW_B       0
`define DSO_BIT_BM_LO      1
`define DSO_BIT_BM_HI      2
`define DSO_BIT_DMODE_B    0
`define DSO_BIT_DD_A       0
`define DSO_BIT_DD_B       1
`define DSO_BIT_ON_A       0
`define DSO_BIT_ON_B       1
`define DSO_BIT_OTH_LO     2
`define DSO_BIT_OTH_HI     9
`define DSO_BIT_RESTART    16
`define DSO_BIT_OE         0
`define DSO_BIT_EN_A       0
`define DSO_BIT_EN_B       1
`define DSO_BIT_ST_OE      0
`define DSO_BIT_ST_HOLD_A  1
`define DSO_BIT_ST_HOLD_B  2
`define DSO_BIT_ST_TRIG    3
`define DSO_BIT_ST_RUN     4
`define DSO_BIT_ST_CNT_LO  16
`define DSO_BIT_ST_CNT_HI  25

`define DSO_RESET_WORD     32'h0000_0000
`define DSO_N_OTHER        8

`define DSO_CLK_FREQ_KHZ   200000
`define DSO_ON_MIN_MS      400
`define DSO_ON_MAX_MS      800
`define DSO_TICK_CYCLES    (`DSO_CLK_FREQ_KHZ)
`define DSO_TERM_MS        ((`DSO_ON_MIN_MS + `DSO_ON_MAX_MS) / 2)

`endif

// File: dso_pkg.sv
// types shared by the delayed switch-off control
package dso_pkg;

	typedef struct packed {
		logic undervolt;
		logic overvolt;
		logic serial_timeout;
		logic monitor_low;
		logic reset_low;
	} trig_t;

	typedef enum logic {
		ST_NORMAL,
		ST_DELAYED
	} dso_state_t;

	typedef struct packed {
		logic [9:0] count;
		logic       running;
		logic       overflow;
	} timer_t;

endpackage

// File: delayed_switch_off_control.sv
// delayed switch-off control for the relay and bridge special outputs
//
// Our own choices: register access over APB and the register offsets.
`include "dso_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module delayed_switch_off_control
#(
	parameter int TICK_CYCLES = `DSO_TICK_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        main_supply_undervolt,
	input  wire logic        main_supply_overvolt,
	input  wire logic        monitor_fault_pin_n,
	input  wire logic        reset_pin_n,
	input  wire logic        serial_timeout,
	input  wire logic        ready_state,
	input  wire logic        sleep_request,
	input  wire logic        protection_active,
	output logic             relay_output_a,
	output logic             bridge_output_b,
	output logic [7:0]       other_stage_drive
);

	localparam logic [9:0] TERM_TICKS = 10'(`DSO_TERM_MS);
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	// pin synchronisers and trigger decode
	logic [3:0]     pin_meta_reg;
	logic [3:0]     pin_sync_reg;
	dso_pkg::trig_t trig;
	logic           any_trig;
	logic           trig_d_reg;
	logic           trig_start;
	logic           volt_clear;

	// register file
	logic [1:0]     delay_mode;
	logic           openload_cfg_a;
	logic           overcurrent_cfg_a;
	logic           freewheel_cfg_b;
	logic [1:0]     bridge_mode_cfg_b;
	logic [1:0]     direct_drive_sel;
	logic [1:0]     on_bit;
	logic [7:0]     other_on_reg;
	logic           global_enable_reg;
	logic [1:0]     channel_enable;
	logic [7:0]     other_enable_reg;
	logic           restart_reg;

	// hold and timer
	logic [1:0]     hold;
	logic [1:0]     hold_next;
	logic [1:0]     normal_on;
	logic [1:0]     end_hold;
	logic [1:0]     out_reg;
	logic [7:0]     other_out_reg;
	logic [31:0]    pre_reg;
	dso_pkg::timer_t tmr;
	logic [9:0]     tmr_count_reg;
	logic [31:0]    prdata_reg;
	logic           wr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return hit(a, `DSO_OFS_OUT_CFG4) || hit(a, `DSO_OFS_BRI_CFG0) ||
			hit(a, `DSO_OFS_BRI_CFG1) || hit(a, `DSO_OFS_DD_CFG2) ||
			hit(a, `DSO_OFS_COMMAND_REG_ZERO) || hit(a, `DSO_OFS_EN_CMD) ||
			hit(a, `DSO_OFS_EN_CFG2) || hit(a, `DSO_OFS_OP_STAT1);
	endfunction

	// apb handshake: zero wait states
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign wr = psel & penable & pwrite & mapped(paddr);
	assign prdata = prdata_reg;

	// two-stage synchroniser on the supply flags and the low-active pins
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
		end
		else
		begin
			pin_meta_reg <= {main_supply_undervolt, main_supply_overvolt,
				~monitor_fault_pin_n, ~reset_pin_n};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	always_comb
	begin
		trig.undervolt = pin_sync_reg[3];
		trig.overvolt = pin_sync_reg[2];
		trig.serial_timeout = serial_timeout;
		trig.monitor_low = pin_sync_reg[1];
		trig.reset_low = pin_sync_reg[0];
	end

	assign any_trig = |trig;
	assign trig_start = any_trig & ~trig_d_reg;
	assign volt_clear = trig.undervolt | trig.reset_low;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			trig_d_reg <= 1'b0;
		else
			trig_d_reg <= any_trig;
	end

	// configuration registers of the special outputs
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			delay_mode <= 2'h0;
			openload_cfg_a <= 1'b0;
			overcurrent_cfg_a <= 1'b0;
			freewheel_cfg_b <= 1'b0;
			bridge_mode_cfg_b <= 2'h0;
			direct_drive_sel <= 2'h0;
		end
		else
		begin
			if (wr && hit(paddr, `DSO_OFS_OUT_CFG4))
			begin
				delay_mode[0] <= pwdata[`DSO_BIT_DMODE_A];
				openload_cfg_a <= pwdata[`DSO_BIT_OL_A];
				overcurrent_cfg_a <= pwdata[`DSO_BIT_OC_A];
			end
			if (wr && hit(paddr, `DSO_OFS_BRI_CFG0))
			begin
				freewheel_cfg_b <= pwdata[`DSO_BIT_FW_B];
				bridge_mode_cfg_b <= pwdata[`DSO_BIT_BM_HI:`DSO_BIT_BM_LO];
			end
			if (wr && hit(paddr, `DSO_OFS_BRI_CFG1))
				delay_mode[1] <= pwdata[`DSO_BIT_DMODE_B];
			if (wr && hit(paddr, `DSO_OFS_DD_CFG2))
				direct_drive_sel <= pwdata[`DSO_BIT_DD_B:`DSO_BIT_DD_A];
			// delay-mode bits survive; a clear bit only clears its own channel's config
			if (volt_clear)
			begin
				if (!delay_mode[0])
				begin
					openload_cfg_a <= 1'b0;
					overcurrent_cfg_a <= 1'b0;
				end
				if (!delay_mode[1])
				begin
					freewheel_cfg_b <= 1'b0;
					bridge_mode_cfg_b <= 2'h0;
				end
			end
		end
	end

	// control bits and restart command
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			on_bit <= 2'h0;
			other_on_reg <= 8'h00;
			restart_reg <= 1'b0;
		end
		else
		begin
			restart_reg <= wr && hit(paddr, `DSO_OFS_COMMAND_REG_ZERO) &&
				pwdata[`DSO_BIT_RESTART];
			if (wr && hit(paddr, `DSO_OFS_COMMAND_REG_ZERO))
			begin
				if (|hold)
				begin
					// only switch-off is taken while a hold runs
					on_bit <= on_bit & pwdata[`DSO_BIT_ON_B:`DSO_BIT_ON_A];
					other_on_reg <= other_on_reg &
						pwdata[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO];
				end
				else
				begin
					on_bit <= pwdata[`DSO_BIT_ON_B:`DSO_BIT_ON_A];
					other_on_reg <= pwdata[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO];
				end
			end
			// only channels without delay mode lose their on bit
			if (volt_clear && !delay_mode[0])
				on_bit[0] <= 1'b0;
			if (volt_clear && !delay_mode[1])
				on_bit[1] <= 1'b0;
		end
	end

	// global and dedicated enables
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			global_enable_reg <= 1'b0;
			channel_enable <= 2'h0;
			other_enable_reg <= 8'h00;
		end
		else
		begin
			if (wr && hit(paddr, `DSO_OFS_EN_CMD))
			begin
				global_enable_reg <= pwdata[`DSO_BIT_OE];
				if (!pwdata[`DSO_BIT_OE])
				begin
					channel_enable <= 2'h0;
					other_enable_reg <= 8'h00;
				end
				else if (!protection_active)
				begin
					channel_enable <= 2'h3;
					other_enable_reg <= 8'hff;
				end
			end
			if (wr && hit(paddr, `DSO_OFS_EN_CFG2))
			begin
				if (protection_active)
				begin
					channel_enable <= channel_enable &
						pwdata[`DSO_BIT_EN_B:`DSO_BIT_EN_A];
					other_enable_reg <= other_enable_reg &
						pwdata[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO];
				end
				else
				begin
					channel_enable <= pwdata[`DSO_BIT_EN_B:`DSO_BIT_EN_A];
					other_enable_reg <= pwdata[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO];
				end
			end
			if (any_trig)
				other_enable_reg <= 8'h00;
			if (volt_clear)
			begin
				if (!(|delay_mode))
					global_enable_reg <= 1'b0;
				if (!delay_mode[0])
					channel_enable[0] <= 1'b0;
				if (!delay_mode[1])
					channel_enable[1] <= 1'b0;
			end
		end
	end

	// per-channel hold state machine and output stage
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_ch
			dso_pkg::dso_state_t st_reg;
			dso_pkg::dso_state_t st_next;
			logic                out_bit_reg;

			assign normal_on[i] = global_enable_reg & channel_enable[i] &
				on_bit[i] & ~direct_drive_sel[i];
			assign end_hold[i] = tmr.overflow |
				~normal_on[i] |
				~delay_mode[i] |
				(ready_state & ~any_trig) |
				sleep_request;

			always_comb
			begin
				st_next = st_reg;
				case (st_reg)
					dso_pkg::ST_NORMAL:
					begin
						if (trig_start && delay_mode[i] && out_reg[i] &&
							!end_hold[i])
							st_next = dso_pkg::ST_DELAYED;
					end
					dso_pkg::ST_DELAYED:
					begin
						if (end_hold[i])
							st_next = dso_pkg::ST_NORMAL;
					end
					default:
						st_next = dso_pkg::ST_NORMAL;
				endcase
			end

			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					st_reg <= dso_pkg::ST_NORMAL;
				else
					st_reg <= st_next;
			end

			assign hold[i] = (st_reg == dso_pkg::ST_DELAYED);
			assign hold_next[i] = (st_next == dso_pkg::ST_DELAYED);

			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
					out_bit_reg <= 1'b0;
				else
					out_bit_reg <= hold_next[i] |
						(normal_on[i] & ~any_trig & ~sleep_request);
			end

			assign out_reg[i] = out_bit_reg;
		end
	endgenerate

	assign relay_output_a = out_reg[0];
	assign bridge_output_b = out_reg[1];
	assign other_stage_drive = other_out_reg;

	// remaining power stages are dropped on any trigger
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			other_out_reg <= 8'h00;
		else
			other_out_reg <= other_on_reg & other_enable_reg &
				{8{global_enable_reg & ~any_trig}};
	end

	// delay timer: ms prescaler then tick counter
	assign tmr = '{count: tmr_count_reg, running: |hold,
		overflow: (tmr_count_reg == TERM_TICKS)};

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= 32'h0000_0000;
			tmr_count_reg <= 10'h000;
		end
		else if (!tmr.running || restart_reg)
		begin
			pre_reg <= 32'h0000_0000;
			tmr_count_reg <= 10'h000;
		end
		else if (pre_reg == TICK_LAST)
		begin
			pre_reg <= 32'h0000_0000;
			if (!tmr.overflow)
				tmr_count_reg <= tmr_count_reg + 10'h001;
		end
		else
			pre_reg <= pre_reg + 32'h0000_0001;
	end

	// read data captured in the setup phase
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			prdata_reg <= `DSO_RESET_WORD;
		else if (psel && !penable)
		begin
			prdata_reg <= `DSO_RESET_WORD;
			if (hit(paddr, `DSO_OFS_OUT_CFG4))
			begin
				prdata_reg[`DSO_BIT_DMODE_A] <= delay_mode[0];
				prdata_reg[`DSO_BIT_OL_A] <= openload_cfg_a;
				prdata_reg[`DSO_BIT_OC_A] <= overcurrent_cfg_a;
			end
			if (hit(paddr, `DSO_OFS_BRI_CFG0))
			begin
				prdata_reg[`DSO_BIT_FW_B] <= freewheel_cfg_b;
				prdata_reg[`DSO_BIT_BM_HI:`DSO_BIT_BM_LO] <= bridge_mode_cfg_b;
			end
			if (hit(paddr, `DSO_OFS_BRI_CFG1))
				prdata_reg[`DSO_BIT_DMODE_B] <= delay_mode[1];
			if (hit(paddr, `DSO_OFS_DD_CFG2))
				prdata_reg[`DSO_BIT_DD_B:`DSO_BIT_DD_A] <= direct_drive_sel;
			if (hit(paddr, `DSO_OFS_COMMAND_REG_ZERO))
			begin
				prdata_reg[`DSO_BIT_ON_B:`DSO_BIT_ON_A] <= on_bit;
				prdata_reg[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO] <= other_on_reg;
			end
			if (hit(paddr, `DSO_OFS_EN_CMD))
				prdata_reg[`DSO_BIT_OE] <= global_enable_reg;
			if (hit(paddr, `DSO_OFS_EN_CFG2))
			begin
				prdata_reg[`DSO_BIT_EN_B:`DSO_BIT_EN_A] <= channel_enable;
				prdata_reg[`DSO_BIT_OTH_HI:`DSO_BIT_OTH_LO] <= other_enable_reg;
			end
			if (hit(paddr, `DSO_OFS_OP_STAT1))
			begin
				prdata_reg[`DSO_BIT_ST_OE] <= global_enable_reg;
				prdata_reg[`DSO_BIT_ST_HOLD_A] <= hold[0];
				prdata_reg[`DSO_BIT_ST_HOLD_B] <= hold[1];
				prdata_reg[`DSO_BIT_ST_TRIG] <= any_trig;
				prdata_reg[`DSO_BIT_ST_RUN] <= tmr.running;
				prdata_reg[`DSO_BIT_ST_CNT_HI:`DSO_BIT_ST_CNT_LO] <= tmr.count;
			end
		end
	end

endmodule

`default_nettype wire

// File: dso_checker_asserts.sv
// concurrent checks on the delayed switch-off control ports
`timescale 1ns/10ps
`default_nettype none
module dso_checker_asserts
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        main_supply_undervolt,
	input wire logic        main_supply_overvolt,
	input wire logic        monitor_fault_pin_n,
	input wire logic        reset_pin_n,
	input wire logic        serial_timeout,
	input wire logic        ready_state,
	input wire logic        sleep_request,
	input wire logic        protection_active,
	input wire logic        relay_output_a,
	input wire logic        bridge_output_b,
	input wire logic [7:0]  other_stage_drive
);
	int   hold_cyc;
	logic wr_acc;
	logic restart;
	assign wr_acc = psel && penable && pwrite;
	assign restart = wr_acc && paddr == 8'h10 && pwdata[16];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// cycles output a stays on under a standing timeout
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_cyc <= 0;
		else if (!(relay_output_a && serial_timeout) || restart)
			hold_cyc <= 0;
		else
			hold_cyc <= hold_cyc + 1;
	end
	AST_POR_OFF: assert property (disable iff (1'b0) !rst_n |->
		!relay_output_a && !bridge_output_b && other_stage_drive == 8'h00)
		else $error("outputs on during reset");
	AST_NO_SWITCH_ON: assert property ($rose(relay_output_a) ||
		$rose(bridge_output_b) |-> !$past(serial_timeout))
		else $error("output switched on under trigger");
	AST_OTHER_OFF_TO: assert property (serial_timeout |=>
		other_stage_drive == 8'h00) else $error("stage on after timeout");
	AST_OTHER_OFF_UV: assert property (main_supply_undervolt [*4] |=>
		other_stage_drive == 8'h00) else $error("stage on in undervolt");
	AST_HOLD_BOUND: assert property (hold_cyc <= 800 * TICK_CYCLES)
		else $error("held output not released");
	AST_SLEEP_OFF: assert property (sleep_request |=>
		!relay_output_a && !bridge_output_b) else $error("on in sleep");
	AST_ON_CLR: assert property (wr_acc && paddr == 8'h10 && !pwdata[0]
		|-> ##2 !relay_output_a) else $error("a on after on bit clear");
	AST_MODE_CLR: assert property (wr_acc && paddr == 8'h00 &&
		!pwdata[0] && serial_timeout ##1 serial_timeout [*2] |=>
		!relay_output_a) else $error("a held after mode clear");
	cover property (hold_cyc == 400 * TICK_CYCLES);
	cover property (sleep_request && relay_output_a);
	cover property (restart && relay_output_a);
endmodule
bind delayed_switch_off_control dso_checker_asserts
	#(.TICK_CYCLES(TICK_CYCLES)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.main_supply_undervolt(main_supply_undervolt),
	.main_supply_overvolt(main_supply_overvolt),
	.monitor_fault_pin_n(monitor_fault_pin_n), .reset_pin_n(reset_pin_n),
	.serial_timeout(serial_timeout), .ready_state(ready_state),
	.sleep_request(sleep_request), .protection_active(protection_active),
	.relay_output_a(relay_output_a), .bridge_output_b(bridge_output_b),
	.other_stage_drive(other_stage_drive));
`default_nettype wire

// File: host_model.sv
// host side: apb master and output setup sequence
`timescale 1ns/10ps
`default_nettype none
module host_model
(
	input  wire logic        ref_clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	output logic             hung
);
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hung = 1'h0;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		hung <= pready !== 1'h1;
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'h1, a, d, r, e);
	endtask
	// serial control, switch mode, delay modes, enable, all on
	task setup(input logic ma, input logic mb);
		wr(8'h0c, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h00, {31'h0, ma});
		wr(8'h08, {31'h0, mb});
		wr(8'h14, 32'h1);
		wr(8'h10, 32'h3ff);
	endtask
endmodule
`default_nettype wire

// File: tb_delayed_switch_off_control.sv
// testbench for the delayed switch-off control
`timescale 1ns/10ps
`default_nettype none
module tb_delayed_switch_off_control;
	localparam int T = 4;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, other;
	logic [31:0] pwdata, prdata, rd;
	logic        uv, ov, mon_n, rpin_n, tmo, rdy, slp, prot;
	logic        out_a, out_b, hung, er;
	int          err_total = 0, cmp_count = 0, n;
	delayed_switch_off_control #(.TICK_CYCLES(T))
	i_delayed_switch_off_control (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .main_supply_undervolt(uv),
		.main_supply_overvolt(ov), .monitor_fault_pin_n(mon_n),
		.reset_pin_n(rpin_n), .serial_timeout(tmo), .ready_state(rdy),
		.sleep_request(slp), .protection_active(prot),
		.relay_output_a(out_a), .bridge_output_b(out_b),
		.other_stage_drive(other));
	host_model i_host_model (.ref_clk(ref_clk), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .hung(hung));
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge hung)
	begin
		err_total++;
		give_verdict;
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] x, input string m);
		cmp_count++;
		if (s !== x)
		begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task rd_reg(input logic [7:0] a);
		i_host_model.xfer(1'h0, a, 32'h0, rd, er);
	endtask
	task wait_off;
		n = 0;
		while (out_a === 1'h1 && n < 900 * T)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n >= 400 * T && n <= 800 * T), 32'h1, "hold time");
		if (n >= 900 * T)
			give_verdict;
	endtask
	task t_normal;
		rd_reg(8'h00);
		chk(rd, 32'h0, "cfg reset value");
		rd_reg(8'h20);
		chk({31'h0, er}, 32'h1, "unmapped error");
		i_host_model.setup(1'h0, 1'h0);
		cyc(3);
		chk({out_a, out_b, other}, 32'h3ff, "all on");
		@(posedge ref_clk) tmo <= 1'h1;
		i_host_model.wr(8'h00, 32'h0);
		cyc(2);
		chk({out_a, out_b, other}, 32'h0, "all off");
		@(posedge ref_clk) tmo <= 1'h0;
		cyc(3);
		chk({out_a, out_b, other}, 32'h300, "others cleared");
		@(posedge ref_clk) prot <= 1'h1;
		i_host_model.wr(8'h14, 32'h1);
		cyc(3);
		chk({24'h0, other}, 32'h0, "protected");
		@(posedge ref_clk) prot <= 1'h0;
		$display("test normal done");
	endtask
	task t_hold;
		i_host_model.setup(1'h1, 1'h1);
		@(posedge ref_clk) tmo <= 1'h1;
		wait_off;
		@(posedge ref_clk) tmo <= 1'h0;
		i_host_model.setup(1'h1, 1'h1);
		@(posedge ref_clk) mon_n <= 1'h0;
		cyc(300 * T);
		chk({31'h0, out_a}, 32'h1, "held by monitor");
		i_host_model.wr(8'h10, 32'h0001_0003);
		wait_off;
		@(posedge ref_clk) mon_n <= 1'h1;
		cyc(4);
		$display("test hold done");
	endtask
	task t_end;
		for (int k = 0; k < 5; k++)
		begin
			i_host_model.setup(1'h1, 1'h1);
			@(posedge ref_clk) rpin_n <= 1'h0;
			cyc(6);
			i_host_model.wr(8'h10, 32'h3ff);
			cyc(3);
			chk({24'h0, other}, 32'h0, "switch on refused");
			rd_reg(8'h00);
			chk(rd, 32'h1, "mode kept");
			rd_reg(8'h18);
			chk(rd & 32'h3, 32'h3, "enables kept");
			case (k)
				0: i_host_model.wr(8'h10, 32'h0);
				1:
				begin
					i_host_model.wr(8'h00, 32'h0);
					i_host_model.wr(8'h08, 32'h0);
				end
				2: @(posedge ref_clk) rdy <= 1'h1;
				3: @(posedge ref_clk) slp <= 1'h1;
				default: i_host_model.wr(8'h14, 32'h0);
			endcase
			if (k == 2)
				rpin_n <= 1'h1;
			cyc(6);
			rd_reg(8'h1c);
			chk(rd & 32'h03ff_0016, 32'h0, "hold ended");
			@(posedge ref_clk)
			begin
				rpin_n <= 1'h1;
				rdy <= 1'h0;
				slp <= 1'h0;
			end
			cyc(4);
		end
		$display("test end done");
	endtask
	task t_por;
		i_host_model.setup(1'h1, 1'h1);
		@(posedge ref_clk) uv <= 1'h1;
		cyc(8);
		chk({31'h0, out_a}, 32'h1, "held in undervolt");
		@(posedge ref_clk) rst_n <= 1'h0;
		#1;
		chk({30'h0, out_a, out_b}, 32'h0, "reset off");
		@(posedge ref_clk) uv <= 1'h0;
		cyc(2);
		@(posedge ref_clk) rst_n <= 1'h1;
		cyc(2);
		$display("test por done");
	endtask
	initial
	begin
		ref_clk = 1'h0;
		rst_n = 1'h0;
		{uv, ov, tmo, rdy, slp, prot} = 6'h00;
		{mon_n, rpin_n} = 2'h3;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_normal;
		t_hold;
		t_end;
		t_por;
		give_verdict;
	end
endmodule
`default_nettype wire
